// >>> common/ecc_report_pkg.sv
// How it works
// [R1] Keep an 8-bit ECC status byte for the one addressed data unit.
// [R2] Unit status transaction returns that byte for the unit at its address.
// [R3] Status byte bits 7..4 and bit 2 always read zero.
// [R4] Bit 3 flags a detected double-bit error when config bit 3 is one.
// [R5] With config bit 3 zero the double-bit flag always reads zero.
// [R6] Double detection on: reprogramming a unit gives program error, not ECC-off.
// [R7] Bit 1 reads one when a single-bit error was corrected in the unit.
// [R8] Bit 0 reads one when ECC is off for the unit; gated by config bit 3.
// [R9] Keep an 8-bit event register of single and double errors since clear.
// [R10] Event register bits are volatile, hardware set, read-only to the host.
// [R11] Array reads update the event register; read-any-register returns it.
// [R12] Host reads the array first, then reads the event register.
// [R13] Power-on, signalling, pin, software reset and clear command empty it.
// [R14] Trap register keeps the address of the first ECC error after reset.
// [R15] Tally counter counts each main-array unit read with a single or double error.
// [R16] ECC works on 16-byte data units with hidden check code.
// [R17] Trap contents are valid only while event bit 3 or 4 is one.
// [R18] Tally is 16 bits and sticks at its maximum instead of wrapping.
// [R19] Trap is 32 bits and takes only the first error of the enabled type.
`default_nettype none
package ecc_report_pkg;

    // Serial command codes
    localparam logic [7:0] CMD_READ_ANY_REG = 8'h65;
    localparam logic [7:0] CMD_WRITE_ANY_REG = 8'h71;
    localparam logic [7:0] CMD_READ_UNIT_STATUS = 8'h19;
    localparam logic [7:0] CMD_CLEAR_ECC = 8'h82;
    localparam logic [7:0] CMD_SOFT_RESET = 8'hF0;

    // Register addresses in the register space
    localparam logic [31:0] ADDR_CONFIG_FOUR = 32'h0080_0005;
    localparam logic [31:0] ADDR_EVENT_STATUS = 32'h0080_0089;
    localparam logic [31:0] ADDR_TRAP_BASE = 32'h0080_003E;
    localparam logic [31:0] ADDR_TALLY_BASE = 32'h0080_0044;
    localparam logic [31:0] TRAP_BYTES = 32'h0000_0004;
    localparam logic [31:0] TALLY_BYTES = 32'h0000_0002;
    localparam logic [31:0] UNIT_ALIGN_MASK = 32'hFFFF_FFF0;

    // Field positions
    localparam int EVT_SINGLE_BIT = 3;
    localparam int EVT_DOUBLE_BIT = 4;
    localparam int CFG_DOUBLE_DETECT_BIT = 3;
    localparam int NV_TRAP_DOUBLE_ONLY_BIT = 3;

    // Values after reset, and the tally limit
    localparam logic [7:0] EVENT_RESET = 8'h00;
    localparam logic [31:0] TRAP_RESET = 32'h0000_0000;
    localparam logic [15:0] TALLY_RESET = 16'h0000;
    localparam logic [15:0] TALLY_MAX = 16'hFFFF;
    localparam logic [7:0] CONFIG_RESET = 8'h08;
    localparam logic [7:0] BYTE_ZERO = 8'h00;

    // Bit counts per frame phase, minus one
    localparam logic [5:0] CMD_LAST = 6'h07;
    localparam logic [5:0] ADDR_LAST = 6'h1F;
    localparam logic [5:0] DUMMY_LAST = 6'h07;
    localparam logic [5:0] DATA_LAST = 6'h07;

    typedef enum logic [2:0] {
        REQ_NONE,
        REQ_READ_REG,
        REQ_WRITE_REG,
        REQ_READ_UNIT,
        REQ_CLEAR,
        REQ_SOFT_RESET
    } req_kind_t;

    typedef enum logic [2:0] {
        ST_CMD,
        ST_ADDR,
        ST_DUMMY,
        ST_DATA_IN,
        ST_DATA_OUT,
        ST_IGNORE
    } link_state_t;

    typedef struct packed {
        req_kind_t kind;
        logic [31:0] addr;
        logic [7:0] wdata;
    } link_req_t;

    typedef struct packed {
        logic valid;
        logic main_array;
        logic single_corr;
        logic double_det;
        logic ecc_off;
        logic [31:0] addr;
    } read_event_t;

    typedef struct packed {
        logic single_corr;
        logic double_det;
        logic ecc_off;
    } unit_result_t;

endpackage : ecc_report_pkg
`default_nettype wire

// >>> logic/ecc_error_reporting.sv
`timescale 1ns/10ps
`default_nettype none
module ecc_error_reporting (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic spi_clk,
    input wire logic cs_b,
    input wire logic si_in,
    output logic so_out,
    output logic so_oe,
    input wire logic reset_pin_b,
    input wire logic cs_sig_reset,
    input wire logic [7:0] nv_config_four,
    input wire ecc_report_pkg::read_event_t read_event,
    output logic unit_query_req,
    output logic [31:0] unit_query_addr,
    input wire logic unit_answer_valid,
    input wire ecc_report_pkg::unit_result_t unit_answer,
    input wire logic reprogram_attempt,
    output logic program_error,
    output logic unit_off_mark
);

    ////////////////////////////////////////////////////////////////////////
    // Link domain: frame decoder on spi_clk

    ecc_report_pkg::link_state_t state_reg;
    ecc_report_pkg::link_state_t state_next;
    logic [5:0] bit_cnt_reg;
    logic [31:0] shift_reg;
    logic [31:0] addr_hold_reg;
    logic [7:0] out_shift_reg;
    logic [31:0] shift_in;
    logic [5:0] phase_last;
    logic phase_done;
    logic fire;
    ecc_report_pkg::link_req_t fire_req;
    ecc_report_pkg::link_req_t link_req_reg;
    logic req_tgl_reg;
    logic ack_meta_reg;
    logic ack_sync_reg;
    logic answer_ready;
    logic [7:0] out_load;

    // Core-side answer, stable while its toggle is in flight
    logic ack_tgl_reg;
    logic [7:0] resp_byte_reg;

    assign shift_in = {shift_reg[30:0], si_in};
    assign answer_ready = (ack_sync_reg == req_tgl_reg);
    // A late core answer gives a defined zero byte rather than stale data
    assign out_load = answer_ready ? resp_byte_reg
                                   : ecc_report_pkg::BYTE_ZERO;
    assign phase_done = (bit_cnt_reg == phase_last);

    always_comb begin
        phase_last = ecc_report_pkg::CMD_LAST;
        state_next = state_reg;
        fire = 1'b0;
        fire_req.kind = ecc_report_pkg::REQ_NONE;
        fire_req.addr = addr_hold_reg;
        fire_req.wdata = ecc_report_pkg::BYTE_ZERO;
        case (state_reg)
            ecc_report_pkg::ST_CMD: begin
                if (phase_done) begin
                    case (shift_in[7:0])
                        ecc_report_pkg::CMD_READ_ANY_REG,
                        ecc_report_pkg::CMD_WRITE_ANY_REG,
                        ecc_report_pkg::CMD_READ_UNIT_STATUS: begin
                            state_next = ecc_report_pkg::ST_ADDR;
                        end
                        ecc_report_pkg::CMD_CLEAR_ECC: begin
                            fire = 1'b1; // see [R13]
                            fire_req.kind = ecc_report_pkg::REQ_CLEAR;
                            state_next = ecc_report_pkg::ST_IGNORE;
                        end
                        ecc_report_pkg::CMD_SOFT_RESET: begin
                            fire = 1'b1; // see [R13]
                            fire_req.kind = ecc_report_pkg::REQ_SOFT_RESET;
                            state_next = ecc_report_pkg::ST_IGNORE;
                        end
                        default: begin
                            state_next = ecc_report_pkg::ST_IGNORE;
                        end
                    endcase
                end
            end
            ecc_report_pkg::ST_ADDR: begin
                phase_last = ecc_report_pkg::ADDR_LAST;
                fire_req.addr = shift_in;
                if (phase_done) begin
                    if (addr_hold_reg[7:0] ==
                        ecc_report_pkg::CMD_WRITE_ANY_REG) begin
                        state_next = ecc_report_pkg::ST_DATA_IN;
                    end else begin
                        fire = 1'b1;
                        fire_req.kind = (addr_hold_reg[7:0] ==
                            ecc_report_pkg::CMD_READ_UNIT_STATUS)
                            ? ecc_report_pkg::REQ_READ_UNIT // see [R2]
                            : ecc_report_pkg::REQ_READ_REG; // see [R11]
                        state_next = ecc_report_pkg::ST_DUMMY;
                    end
                end
            end
            ecc_report_pkg::ST_DUMMY: begin
                phase_last = ecc_report_pkg::DUMMY_LAST;
                if (phase_done) begin
                    state_next = ecc_report_pkg::ST_DATA_OUT;
                end
            end
            ecc_report_pkg::ST_DATA_IN: begin
                phase_last = ecc_report_pkg::DATA_LAST;
                if (phase_done) begin
                    fire = 1'b1;
                    fire_req.kind = ecc_report_pkg::REQ_WRITE_REG;
                    fire_req.wdata = shift_in[7:0];
                    state_next = ecc_report_pkg::ST_IGNORE;
                end
            end
            ecc_report_pkg::ST_DATA_OUT: begin
                phase_last = ecc_report_pkg::DATA_LAST;
            end
            ecc_report_pkg::ST_IGNORE: begin
                phase_last = ecc_report_pkg::DATA_LAST;
            end
            default: begin
                state_next = ecc_report_pkg::ST_IGNORE;
            end
        endcase
    end

    // Frame state ends with the frame: chip select high clears it
    always_ff @(posedge spi_clk or posedge cs_b or negedge rst_b) begin
        if (!rst_b || cs_b) begin
            state_reg <= ecc_report_pkg::ST_CMD;
            bit_cnt_reg <= 6'h00;
            shift_reg <= 32'h0000_0000;
            addr_hold_reg <= 32'h0000_0000;
            out_shift_reg <= ecc_report_pkg::BYTE_ZERO;
        end else begin
            state_reg <= state_next;
            bit_cnt_reg <= (phase_done || state_next != state_reg)
                           ? 6'h00 : bit_cnt_reg + 6'h01;
            shift_reg <= shift_in;
            if (state_reg == ecc_report_pkg::ST_CMD && phase_done) begin
                addr_hold_reg <= {24'h00_0000, shift_in[7:0]};
            end else if (state_reg == ecc_report_pkg::ST_ADDR &&
                         phase_done) begin
                addr_hold_reg <= shift_in;
            end
            if (state_reg == ecc_report_pkg::ST_DUMMY && phase_done) begin
                out_shift_reg <= out_load;
            end else if (state_reg == ecc_report_pkg::ST_DATA_OUT) begin
                out_shift_reg <= {out_shift_reg[6:0], out_shift_reg[7]};
            end
        end
    end

    // The write command code sits in addr_hold_reg only until the address
    // phase ends; the request payload below keeps its own copy.
    always_ff @(posedge spi_clk or negedge rst_b) begin
        if (!rst_b) begin
            link_req_reg <= '0;
            req_tgl_reg <= 1'b0;
            ack_meta_reg <= 1'b0;
            ack_sync_reg <= 1'b0;
        end else begin
            ack_meta_reg <= ack_tgl_reg;
            ack_sync_reg <= ack_meta_reg;
            if (fire) begin
                link_req_reg <= fire_req;
                req_tgl_reg <= ~req_tgl_reg;
            end
        end
    end

    // Data leaves on the falling edge so the host samples it mid-bit
    always_ff @(negedge spi_clk or posedge cs_b or negedge rst_b) begin
        if (!rst_b || cs_b) begin
            so_out <= 1'b0;
            so_oe <= 1'b0;
        end else begin
            so_out <= out_shift_reg[7];
            so_oe <= (state_reg == ecc_report_pkg::ST_DATA_OUT);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain: request intake and reset sources

    logic req_meta_reg;
    logic req_sync_reg;
    logic req_seen_reg;
    logic pin_meta_reg;
    logic pin_sync_reg;
    logic new_req;
    logic is_clear;
    logic is_soft_reset;
    logic is_write;
    logic is_read_reg;
    logic is_read_unit;
    logic clear_all;
    logic reload_cfg;

    assign new_req = (req_sync_reg != req_seen_reg);
    assign is_clear = new_req &&
                      link_req_reg.kind == ecc_report_pkg::REQ_CLEAR;
    assign is_soft_reset = new_req &&
                           link_req_reg.kind == ecc_report_pkg::REQ_SOFT_RESET;
    assign is_write = new_req &&
                      link_req_reg.kind == ecc_report_pkg::REQ_WRITE_REG;
    assign is_read_reg = new_req &&
                         link_req_reg.kind == ecc_report_pkg::REQ_READ_REG;
    assign is_read_unit = new_req &&
                          link_req_reg.kind == ecc_report_pkg::REQ_READ_UNIT;
    assign clear_all = is_clear || is_soft_reset || cs_sig_reset ||
                       !pin_sync_reg; // see [R13]
    assign reload_cfg = is_soft_reset || cs_sig_reset || !pin_sync_reg;

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            req_meta_reg <= 1'b0;
            req_sync_reg <= 1'b0;
            req_seen_reg <= 1'b0;
            pin_meta_reg <= 1'b1;
            pin_sync_reg <= 1'b1;
        end else begin
            req_meta_reg <= req_tgl_reg;
            req_sync_reg <= req_meta_reg;
            req_seen_reg <= req_sync_reg;
            pin_meta_reg <= reset_pin_b;
            pin_sync_reg <= pin_meta_reg;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain: configuration, event register, trap and tally

    logic [7:0] config_reg;
    logic cfg_loaded_reg;
    logic [7:0] event_reg;
    logic [31:0] trap_reg;
    logic trap_full_reg;
    logic [15:0] tally_reg;
    logic double_en;
    logic ev_single;
    logic ev_double;
    logic trap_hit;
    logic [7:0] event_next;
    logic [31:0] trap_base;
    logic trap_full_base;
    logic [15:0] tally_base;
    logic [15:0] tally_next;
    logic tally_inc;

    assign double_en = config_reg[ecc_report_pkg::CFG_DOUBLE_DETECT_BIT];
    assign ev_single = read_event.valid && read_event.single_corr &&
                       !read_event.ecc_off;
    assign ev_double = read_event.valid && read_event.double_det &&
                       double_en && !read_event.ecc_off; // see [R5]

    // Event bits only ever get set by hardware; a clear in the same cycle
    // as an event loses to the event.
    assign event_next =
        (clear_all ? ecc_report_pkg::EVENT_RESET : event_reg) |
        (8'(ev_single) << ecc_report_pkg::EVT_SINGLE_BIT) |
        (8'(ev_double) << ecc_report_pkg::EVT_DOUBLE_BIT); // see [R9] [R10]

    assign trap_hit = ev_double ||
        (ev_single &&
         !nv_config_four[ecc_report_pkg::NV_TRAP_DOUBLE_ONLY_BIT]);
    assign trap_base = clear_all ? ecc_report_pkg::TRAP_RESET : trap_reg;
    assign trap_full_base = !clear_all && trap_full_reg;

    // One count per erroneous main-array unit read; the read engine reports each unit
    // once per transaction, so repeated reads of a bad unit count again.
    assign tally_inc = (ev_single || ev_double) && read_event.main_array;
    assign tally_base = clear_all ? ecc_report_pkg::TALLY_RESET : tally_reg;
    assign tally_next = (tally_inc && tally_base != ecc_report_pkg::TALLY_MAX)
                        ? tally_base + 16'h0001 : tally_base; // see [R18]

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            config_reg <= ecc_report_pkg::CONFIG_RESET;
            cfg_loaded_reg <= 1'b0;
            event_reg <= ecc_report_pkg::EVENT_RESET; // see [R13]
            trap_reg <= ecc_report_pkg::TRAP_RESET;
            trap_full_reg <= 1'b0;
            tally_reg <= ecc_report_pkg::TALLY_RESET;
        end else begin
            cfg_loaded_reg <= 1'b1;
            // Volatile copy follows the stored setting after any reset
            if (reload_cfg || !cfg_loaded_reg) begin
                config_reg <= nv_config_four;
            end else if (is_write &&
                         link_req_reg.addr == ecc_report_pkg::ADDR_CONFIG_FOUR)
            begin
                config_reg <= link_req_reg.wdata;
            end
            event_reg <= event_next; // see [R11]
            trap_full_reg <= trap_full_base || trap_hit;
            if (trap_hit && !trap_full_base) begin
                trap_reg <= read_event.addr; // see [R14] [R19]
            end else begin
                trap_reg <= trap_base;
            end
            tally_reg <= tally_next; // see [R15]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain: answers to register and unit status reads

    logic unit_wait_reg;
    logic [31:0] trap_off;
    logic [31:0] tally_off;
    logic [31:0] trap_sel;
    logic [15:0] tally_sel;
    logic [7:0] reg_byte;
    logic [7:0] unit_byte;
    logic trap_valid;

    assign trap_off = link_req_reg.addr - ecc_report_pkg::ADDR_TRAP_BASE;
    assign tally_off = link_req_reg.addr - ecc_report_pkg::ADDR_TALLY_BASE;
    // Trap reads as zero until an event bit vouches for it
    assign trap_valid = event_reg[ecc_report_pkg::EVT_SINGLE_BIT] ||
                        event_reg[ecc_report_pkg::EVT_DOUBLE_BIT];
    assign trap_sel = trap_valid ? (trap_reg >> {trap_off[1:0], 3'b000})
                                 : 32'h0000_0000; // see [R17]
    assign tally_sel = tally_reg >> {tally_off[0], 3'b000};
    assign reg_byte =
        (link_req_reg.addr == ecc_report_pkg::ADDR_EVENT_STATUS) ? event_reg :
        (link_req_reg.addr == ecc_report_pkg::ADDR_CONFIG_FOUR) ? config_reg :
        (trap_off < ecc_report_pkg::TRAP_BYTES) ? trap_sel[7:0] :
        (tally_off < ecc_report_pkg::TALLY_BYTES) ? tally_sel[7:0] :
        ecc_report_pkg::BYTE_ZERO;

    // Unit byte: reserved bits fixed at zero
    assign unit_byte = {4'h0,
                        unit_answer.double_det && double_en, // see [R4] [R5]
                        1'b0, // see [R3]
                        unit_answer.single_corr, // see [R7]
                        unit_answer.ecc_off && !double_en}; // see [R8] [R6]

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ack_tgl_reg <= 1'b0;
            resp_byte_reg <= ecc_report_pkg::BYTE_ZERO;
            unit_wait_reg <= 1'b0;
            unit_query_req <= 1'b0;
            unit_query_addr <= 32'h0000_0000;
        end else begin
            unit_query_req <= is_read_unit;
            if (is_read_unit) begin
                // Whole 16-byte unit is the unit of ECC status
                unit_query_addr <= link_req_reg.addr &
                                   ecc_report_pkg::UNIT_ALIGN_MASK; // see [R16]
                unit_wait_reg <= 1'b1;
            end else if (unit_wait_reg && unit_answer_valid) begin
                unit_wait_reg <= 1'b0;
                resp_byte_reg <= unit_byte; // see [R1] [R2]
                ack_tgl_reg <= ~ack_tgl_reg;
            end else if (new_req) begin
                if (is_read_reg) begin
                    resp_byte_reg <= reg_byte; // see [R11]
                end
                ack_tgl_reg <= ~ack_tgl_reg;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Core domain: reprogramming of a partly written unit

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            program_error <= 1'b0;
            unit_off_mark <= 1'b0;
        end else begin
            program_error <= reprogram_attempt && double_en; // see [R6]
            unit_off_mark <= reprogram_attempt && !double_en;
        end
    end

endmodule : ecc_error_reporting
`default_nettype wire

// >>> tb/ecc_report_assertions.sv
`timescale 1ns/10ps
`default_nettype none
module ecc_report_assertions (
    input wire logic core_clk,
    input wire logic rst_b,
    input wire logic cs_b,
    input wire logic so_out,
    input wire logic so_oe,
    input wire logic unit_query_req,
    input wire logic [31:0] unit_query_addr,
    input wire logic reprogram_attempt,
    input wire logic program_error,
    input wire logic unit_off_mark
);
    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!rst_b);
    prog_answer_a:
        assert property (reprogram_attempt |=> program_error ^ unit_off_mark)
        else $error("reprogram attempt got no single answer");
    prog_cause_a:
        assert property (program_error |-> $past(reprogram_attempt))
        else $error("program error without a reprogram attempt");
    off_cause_a:
        assert property (unit_off_mark |-> $past(reprogram_attempt))
        else $error("unit off mark without a reprogram attempt");
    query_pulse_a:
        assert property (unit_query_req |=> !unit_query_req)
        else $error("unit query longer than one cycle");
    query_align_a:
        assert property (unit_query_req |-> unit_query_addr[3:0] == 4'h0)
        else $error("unit query address not unit aligned");
    query_hold_a:
        assert property (!unit_query_req |-> $stable(unit_query_addr))
        else $error("unit query address moved between queries");
    oe_frame_a:
        assert property (cs_b |-> !so_oe)
        else $error("serial output driven outside a frame");
    so_quiet_a:
        assert property (!so_oe |-> !so_out)
        else $error("serial output not low while undriven");
endmodule : ecc_report_assertions
bind ecc_error_reporting ecc_report_assertions i_ecc_report_assertions (
    .core_clk(core_clk), .rst_b(rst_b), .cs_b(cs_b), .so_out(so_out),
    .so_oe(so_oe), .unit_query_req(unit_query_req),
    .unit_query_addr(unit_query_addr),
    .reprogram_attempt(reprogram_attempt),
    .program_error(program_error), .unit_off_mark(unit_off_mark));
`default_nettype wire

// >>> tb/spi_host_model.sv
`timescale 1ns/10ps
`default_nettype none
module spi_host_model (
    output logic spi_clk,
    output logic cs_b,
    output logic si_in,
    input wire logic so_out,
    input wire logic so_oe
);
    initial begin
        spi_clk = 1'b0;
        cs_b = 1'b1;
        si_in = 1'b0;
    end
    // Clock stands low between frames; dummy and idle bits keep toggling
    task automatic xfer(input logic [47:0] bits, input int n,
                        input logic rd_on, output logic [7:0] rd);
        rd = 8'h00;
        #7 cs_b = 1'b0;
        for (int i = 0; i < n + (rd_on ? 16 : 0); i++) begin
            si_in = (i < n) ? bits[47 - i] : ~si_in;
            #16 spi_clk = 1'b1;
            // An undriven line reads as the inverse, so a missing enable shows
            if (i >= n + 8) rd = {rd[6:0], so_oe ? so_out : ~so_out};
            #32 spi_clk = 1'b0;
            #16;
        end
        cs_b = 1'b1;
        si_in = ~si_in;
        #200;
    endtask : xfer
endmodule : spi_host_model
`default_nettype wire

// >>> tb/test_ecc_error_reporting.sv
`timescale 1ns/10ps
`default_nettype none
module test_ecc_error_reporting;
    logic core_clk, rst_b, spi_clk, cs_b, si_in, so_out, so_oe, tv, cfg;
    logic reset_pin_b, cs_sig_reset, unit_query_req, unit_answer_valid;
    logic reprogram_attempt, program_error, unit_off_mark;
    logic [7:0] nv_config_four, rd;
    logic [31:0] unit_query_addr, trap, a;
    ecc_report_pkg::read_event_t read_event;
    ecc_report_pkg::unit_result_t unit_answer;
    int mismatches, checks_done, seed, ev, tally, k;
    ecc_error_reporting i_ecc_error_reporting (.core_clk(core_clk),
        .rst_b(rst_b), .spi_clk(spi_clk), .cs_b(cs_b), .si_in(si_in),
        .so_out(so_out), .so_oe(so_oe), .reset_pin_b(reset_pin_b),
        .cs_sig_reset(cs_sig_reset), .nv_config_four(nv_config_four),
        .read_event(read_event), .unit_query_req(unit_query_req),
        .unit_query_addr(unit_query_addr), .unit_answer(unit_answer),
        .unit_answer_valid(unit_answer_valid), .unit_off_mark(unit_off_mark),
        .reprogram_attempt(reprogram_attempt), .program_error(program_error));
    spi_host_model i_spi_host_model (.spi_clk(spi_clk), .cs_b(cs_b),
        .si_in(si_in), .so_out(so_out), .so_oe(so_oe));
    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end
    // Array answers two cycles after each query, well inside its limit
    always @(posedge core_clk) begin
        #2 unit_answer_valid = 1'b0;
        if (unit_query_req === 1'b1) begin
            repeat (2) @(posedge core_clk);
            #2 unit_answer_valid = 1'b1;
        end
    end
    ////////////////////////////////////////////////////////////////////////
    task automatic close_out;
        if (mismatches == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("unexpected at %0t: got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic tick(input int n);
        repeat (n) @(posedge core_clk);
        #2;
    endtask : tick
    task automatic wr(input logic [7:0] c, input logic [39:0] t, input int n);
        i_spi_host_model.xfer({c, t}, n, 1'b0, rd);
    endtask : wr
    task automatic rreg(input logic [31:0] ra);
        i_spi_host_model.xfer({ecc_report_pkg::CMD_READ_ANY_REG, ra, 8'h00},
                              40, 1'b1, rd);
    endtask : rreg
    task automatic event_in(input logic s, input logic d, input logic o);
        logic hs, hd;
        hs = s & ~o;
        hd = d & ~o & cfg;
        tick(1);
        read_event = {1'b1, 1'b1, s, d, o, a};
        tick(1);
        read_event = '0;
        if (hs) ev |= 8;
        if (hd) ev |= 16;
        if (hs | hd) tally++;
        if (!tv && (hd || (hs && !nv_config_four[3]))) begin
            trap = a;
            tv = 1'b1;
        end
    endtask : event_in
    task automatic check_regs;
        logic [31:0] t;
        t = (ev & 24) ? trap : 32'h0000_0000;
        rreg(ecc_report_pkg::ADDR_EVENT_STATUS);
        chk(rd, ev);
        for (int i = 0; i < 2; i++) begin
            rreg(ecc_report_pkg::ADDR_TALLY_BASE + i);
            chk(rd, (tally >> (8 * i)) & 255);
        end
        for (int i = 0; i < 4; i++) begin
            rreg(ecc_report_pkg::ADDR_TRAP_BASE + i);
            chk(rd, t[8 * i +: 8]);
        end
    endtask : check_regs
    ////////////////////////////////////////////////////////////////////////
    initial begin
        {seed, mismatches, checks_done, ev, tally, trap, tv} = '0;
        seed = 84252;
        {rst_b, cs_sig_reset, reprogram_attempt, unit_answer_valid} = '0;
        {read_event, unit_answer, a} = '0;
        reset_pin_b = 1'b1;
        nv_config_four = 8'h00;
        cfg = 1'b1;
        repeat (4) @(posedge core_clk);
        #2 rst_b = 1'b1;
        tick(3);
        check_regs;
        for (int p = 0; p < 2; p++) begin
            cfg = (p == 0);
            // First pass traps either error type, second only double errors
            nv_config_four = {4'h0, p[0], 3'h0};
            wr(ecc_report_pkg::CMD_WRITE_ANY_REG,
               {ecc_report_pkg::ADDR_CONFIG_FOUR, 4'h0, cfg, 3'h0}, 48);
            rreg(ecc_report_pkg::ADDR_CONFIG_FOUR);
            chk(rd, {4'h0, cfg, 3'h0});
            for (k = 0; k < 8; k++) begin
                a = $random(seed);
                unit_answer = k[2:0];
                i_spi_host_model.xfer({ecc_report_pkg::CMD_READ_UNIT_STATUS,
                                       a, 8'h00}, 40, 1'b1, rd);
                chk(rd, {4'h0, k[1] & cfg, 1'b0, k[2], k[0] & ~cfg});
                chk(unit_query_addr, a & 32'hFFFF_FFF0);
            end
            repeat (12) begin
                k = $random(seed);
                a = $random(seed);
                event_in(k[0] & ~k[1], k[1], k[2] & k[3]);
            end
            wr(ecc_report_pkg::CMD_WRITE_ANY_REG,
               {ecc_report_pkg::ADDR_EVENT_STATUS, 8'hFF}, 48);
            check_regs;
            tick(1);
            reprogram_attempt = 1'b1;
            tick(1);
            reprogram_attempt = 1'b0;
            chk({program_error, unit_off_mark}, {cfg, ~cfg});
        end
        for (int m = 0; m < 4; m++) begin
            a = $random(seed);
            event_in(1'b1, 1'b0, 1'b0);
            if (m == 0) wr(ecc_report_pkg::CMD_CLEAR_ECC, '0, 8);
            if (m == 1) wr(ecc_report_pkg::CMD_SOFT_RESET, '0, 8);
            if (m == 2) reset_pin_b = 1'b0;
            if (m == 3) cs_sig_reset = 1'b1;
            tick(5);
            {reset_pin_b, cs_sig_reset} = 2'b10;
            tick(8);
            {ev, tally, trap, tv} = '0;
            cfg = (m != 0);
            check_regs;
        end
        close_out;
    end
    initial begin
        repeat (40000) @(posedge core_clk);
        mismatches++;
        close_out;
    end
endmodule : test_ecc_error_reporting
`default_nettype wire
